// [rur_remap_window.sv]
`timescale 1ns/1ps
`default_nettype none
// Function
// - A table of 120 index entries sits at 1280h..12F7h, each holding a source address.
// - Reading window slot n at 0100h..0177h returns the register named by index entry n.
// - Any source address value is accepted into an index entry, unchecked.
// - Index entries are written with function 06 or 16, and both are accepted.
// - Index entry k is located at the index base plus k.
// - Index contents are kept in the setpoint store and restored after power-up.
// - One read over adjacent slots returns every mapped value in index order.
// - Slots 100h..102h default to sources 0014h..0016h.
// - Slots 103h..105h default to sources 001Ah..001Ch.
// - Slots 106h..108h default to 0022h..0024h and 109h..110h to 0030h..0037h.
// - Slots 111h..11Dh default to the listed run 0010h through 0056h.
// - Defaults come in four polling groups, yet every entry stays writable.
// - Every address in the block designates one 16-bit word.
// - An address outside the allowed regions draws exception code 02.
// - A request with a CRC error is dropped with no answer at all.
module rur_remap_window import rur_pkg::*; (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // parsed requests from the frame engine
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire logic [7:0]  reqFunc,
  input  wire logic [15:0] reqAddr,
  input  wire logic [7:0]  reqCount,
  input  wire logic [15:0] reqWdata,
  input  wire logic        reqCrcOk,
  // answers to the frame engine
  output logic             rspValid,
  output logic [15:0]      rspData,
  output logic             rspLast,
  output logic             excValid,
  output logic [7:0]       excCode,
  // live register map fetch
  output logic             srcReq,
  output logic [15:0]      srcAddr,
  input  wire logic        srcValid,
  input  wire logic [15:0] srcRdata,
  // setpoint store
  output logic             nvRdReq,
  output logic [6:0]       nvRdIdx,
  input  wire logic        nvRdValid,
  input  wire logic [15:0] nvRdData,
  input  wire logic        nvBlank,
  output logic             nvWrValid,
  output logic [6:0]       nvWrIdx,
  output logic [15:0]      nvWrData
);
  typedef enum logic [2:0] {ST_LOAD, ST_IDLE, ST_IDXRD, ST_FETCH, ST_WAIT} rur_state_e;

  rur_state_e  state;
  rur_state_e  next_state;
  logic [15:0] curAddr;
  logic [7:0]  remain;

  rur_tbl_if   tbl();

  logic        ldWrEn;
  logic [6:0]  ldIdx;
  logic [15:0] ldData;
  logic        ldDone;

  // power-up restore of the index from the setpoint store
  rur_nv_loader u_loader (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .nvRdReq   (nvRdReq),
    .nvRdIdx   (nvRdIdx),
    .nvRdValid (nvRdValid),
    .nvRdData  (nvRdData),
    .nvBlank   (nvBlank),
    .ldWrEn    (ldWrEn),
    .ldIdx     (ldIdx),
    .ldData    (ldData),
    .ldDone    (ldDone)
  );

  rur_index_store u_store (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tbl     (tbl.store)
  );

  // request decode
  logic        accept;
  logic        goodReq;
  logic        isRead;
  logic        isWrite;
  logic [7:0]  span;
  logic        idxHit;
  logic        winHit;
  logic        cntBad;
  logic        hostWr;
  logic        excNow;
  logic [7:0]  excSel;
  assign accept  = reqValid && reqReady;
  assign goodReq = accept && reqCrcOk;
  assign isRead  = (reqFunc == FN_RD_HOLD) || (reqFunc == FN_RD_INPUT);
  assign isWrite = (reqFunc == FN_WR_SINGLE) || (reqFunc == FN_WR_MULTI);
  // each write request carries one word, so its span is one address
  assign span    = isWrite ? 8'h01 : reqCount;
  assign idxHit  = inRange(reqAddr, span, IDX_BASE, IDX_LAST);
  assign winHit  = inRange(reqAddr, span, WIN_BASE, WIN_LAST);
  assign cntBad  = isRead && ((reqCount == 8'h00) || (reqCount > WIN_WORDS));
  assign hostWr  = goodReq && isWrite && idxHit;

  // exception selection: function first, then value, then address
  assign excNow  = goodReq && (!(isRead || isWrite) || cntBad ||
                   (isRead && !idxHit && !winHit) || (isWrite && !idxHit));
  assign excSel  = !(isRead || isWrite) ? EXC_FUNC : (cntBad ? EXC_VALUE : EXC_ADDR);

  // table ports: loader owns the write side until the restore finishes
  logic [15:0] wrOff;
  logic [15:0] curOff;
  assign wrOff      = reqAddr - IDX_BASE;
  assign curOff     = curAddr - ((state == ST_IDXRD) ? IDX_BASE : WIN_BASE);
  assign tbl.wrEn   = ldWrEn || hostWr;
  assign tbl.wrIdx  = ldWrEn ? ldIdx : wrOff[6:0];
  // any address value is stored as is; no range check on the source
  assign tbl.wrData = ldWrEn ? ldData : reqWdata;
  assign tbl.rdIdx  = curOff[6:0];

  // word stepping
  logic        wordLast;
  logic        wordStep;
  logic [15:0] next_rspData;
  assign wordLast     = (remain == 8'h01);
  assign wordStep     = (state == ST_IDXRD) || ((state == ST_WAIT) && srcValid);
  // the live fetch result, never a copy taken at index write time
  assign next_rspData = (state == ST_IDXRD) ? tbl.rdData :
                        (state == ST_WAIT)  ? srcRdata : reqWdata;

  // next state
  always_comb begin
    next_state = state;
    case (state)
      ST_LOAD: begin
        if (ldDone) next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (goodReq && isRead && !cntBad) begin
          if (winHit) next_state = ST_FETCH;
          else if (idxHit) next_state = ST_IDXRD;
        end
      end
      ST_IDXRD: begin
        if (wordLast) next_state = ST_IDLE;
      end
      ST_FETCH: next_state = ST_WAIT;
      ST_WAIT: begin
        if (srcValid) next_state = wordLast ? ST_IDLE : ST_FETCH;
      end
      default: next_state = ST_LOAD;
    endcase
  end

  // state and request handshake; busy while restoring or streaming
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state    <= ST_LOAD;
      reqReady <= 1'b0;
    end else begin
      state    <= next_state;
      reqReady <= (next_state == ST_IDLE);
    end
  end

  // read cursor walks the slots in index order
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      curAddr <= 16'h0000;
      remain  <= 8'h00;
    end else if (goodReq && isRead) begin
      curAddr <= reqAddr;
      remain  <= reqCount;
    end else if (wordStep) begin
      curAddr <= curAddr + 16'h0001;
      remain  <= remain - 8'h01;
    end
  end

  // answer words: one per slot, write echoes close with rspLast
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rspValid <= 1'b0;
      rspData  <= 16'h0000;
      rspLast  <= 1'b0;
      excValid <= 1'b0;
      excCode  <= 8'h00;
    end else begin
      rspValid <= wordStep || hostWr;
      rspData  <= next_rspData;
      rspLast  <= hostWr || (wordStep && wordLast);
      excValid <= excNow;
      excCode  <= excNow ? excSel : excCode;
    end
  end

  // slot resolution: the index entry names the live register to fetch
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      srcReq  <= 1'b0;
      srcAddr <= 16'h0000;
    end else begin
      srcReq  <= (state == ST_FETCH);
      srcAddr <= (state == ST_FETCH) ? tbl.rdData : srcAddr;
    end
  end

  // host writes go to the setpoint store so the remap survives power loss
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nvWrValid <= 1'b0;
      nvWrIdx   <= 7'h00;
      nvWrData  <= 16'h0000;
    end else begin
      nvWrValid <= hostWr;
      nvWrIdx   <= hostWr ? wrOff[6:0] : nvWrIdx;
      nvWrData  <= hostWr ? reqWdata : nvWrData;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_crc_silent: assert property (
    accept && !reqCrcOk |=> !rspValid && !excValid && reqReady)
    else $error("request with bad crc was answered");

  // a dropped frame must neither touch the store nor start a read
  a_crc_no_store: assert property (
    accept && !reqCrcOk |=> !nvWrValid && (state == ST_IDLE))
    else $error("request with bad crc changed state");

  a_bad_address: assert property (
    goodReq && isRead && !cntBad && !idxHit && !winHit |=> excValid && excCode == EXC_ADDR)
    else $error("unmapped read gave no address exception");

  a_value_code: assert property (
    goodReq && isRead && ((reqCount == 8'h00) || (reqCount > WIN_WORDS))
    |=> excValid && excCode == EXC_VALUE && !rspValid)
    else $error("bad word count gave no value exception");

  a_window_write: assert property (
    goodReq && isWrite && winHit |=> excValid && excCode == EXC_ADDR && !nvWrValid)
    else $error("write into window was not refused");

  a_exc_alone: assert property (excValid |-> !rspValid)
    else $error("exception and data answer together");

  a_both_writes: assert property (
    goodReq && idxHit && ((reqFunc == FN_WR_SINGLE) || (reqFunc == FN_WR_MULTI))
    |=> rspValid && rspLast && !excValid && rspData == $past(reqWdata))
    else $error("index write not acknowledged");

  // the entry number is the distance from the index base
  a_index_offset: assert property (
    hostWr |-> (IDX_BASE + {9'h000, tbl.wrIdx}) == reqAddr)
    else $error("index write landed on the wrong entry");

  a_nv_mirror: assert property (
    hostWr |=> nvWrValid && nvWrData == $past(reqWdata) && nvWrIdx == $past(reqAddr[6:0]))
    else $error("index write not sent to setpoint store");

  a_slot_target: assert property (
    srcReq |-> $past(state) == ST_FETCH && srcAddr == $past(tbl.rdData))
    else $error("fetch address differs from index entry");

  // the slot being resolved sits as far above the window base as its entry
  a_window_slot: assert property (
    (state == ST_FETCH) |-> (WIN_BASE + {9'h000, tbl.rdIdx}) == curAddr)
    else $error("window slot read the wrong index entry");

  a_index_slot: assert property (
    (state == ST_IDXRD) |-> (IDX_BASE + {9'h000, tbl.rdIdx}) == curAddr)
    else $error("index read used the wrong entry");

  a_live_value: assert property (
    (state == ST_WAIT) && srcValid |=> rspValid && rspData == $past(srcRdata))
    else $error("slot answer is not the fetched value");

  a_index_order: assert property (
    wordStep && !wordLast
    |=> curAddr == $past(curAddr) + 16'h0001 && remain == $past(remain) - 8'h01)
    else $error("slot walk out of order");

  // the final word of every read closes the answer and frees the port
  a_last_word: assert property (
    wordStep && wordLast |=> rspValid && rspLast && reqReady)
    else $error("last word of a read not marked");

  a_fetch_bound: assert property (
    (state == ST_FETCH) |=> srcReq ##0 (state == ST_WAIT))
    else $error("fetch request not issued");

  a_load_busy: assert property ((state == ST_LOAD) |-> !reqReady)
    else $error("request taken during restore");

  c_window_burst: cover property ((state == ST_WAIT) && srcValid && wordLast && (remain == 8'h01)
    ##1 rspLast);
  c_index_read: cover property ((state == ST_IDXRD) && wordLast ##1 rspLast);
  c_index_write: cover property (hostWr ##1 nvWrValid);
  c_crc_drop: cover property (accept && !reqCrcOk);
  c_addr_exc: cover property (excValid && excCode == EXC_ADDR);
endmodule // rur_remap_window
`default_nettype wire

// [rur_pkg.sv]
`default_nettype none
package rur_pkg;
  // map layout, one 16-bit word per address
  localparam logic [15:0] IDX_BASE     = 16'h1280;
  localparam logic [15:0] IDX_LAST     = 16'h12f7;
  localparam logic [15:0] WIN_BASE     = 16'h0100;
  localparam logic [15:0] WIN_LAST     = 16'h0177;
  localparam logic [7:0]  WIN_WORDS    = 8'h78;
  localparam logic [6:0]  IDX_TOP      = 7'h77;
  localparam logic [15:0] IDX_RESET    = 16'h0000;
  // function and exception codes of the register protocol
  localparam logic [7:0]  FN_RD_HOLD   = 8'h03;
  localparam logic [7:0]  FN_RD_INPUT  = 8'h04;
  localparam logic [7:0]  FN_WR_SINGLE = 8'h06;
  localparam logic [7:0]  FN_WR_MULTI  = 8'h10;
  localparam logic [7:0]  EXC_FUNC     = 8'h01;
  localparam logic [7:0]  EXC_ADDR     = 8'h02;
  localparam logic [7:0]  EXC_VALUE    = 8'h03;
  // factory index groups: first source of each run
  localparam logic [15:0] DEF_ALARM    = 16'h0014;
  localparam logic [15:0] DEF_TRIP     = 16'h001a;
  localparam logic [15:0] DEF_MODE     = 16'h0022;
  localparam logic [15:0] DEF_CURRENT  = 16'h0030;

  // factory source address of one index entry
  function automatic logic [15:0] defaultIndex(input logic [6:0] idx);
    logic [15:0] i;
    i = {9'h000, idx};
    if (idx <= 7'h02) return DEF_ALARM + i;
    if (idx <= 7'h05) return DEF_TRIP + i - 16'h0003;
    if (idx <= 7'h08) return DEF_MODE + i - 16'h0006;
    if (idx <= 7'h10) return DEF_CURRENT + i - 16'h0009;
    case (idx)
      7'h11:   return 16'h0010;
      7'h12:   return 16'h0013;
      7'h13:   return 16'h0021;
      7'h14:   return 16'h0038;
      7'h15:   return 16'h0039;
      7'h16:   return 16'h003a;
      7'h17:   return 16'h0050;
      7'h18:   return 16'h0051;
      7'h19:   return 16'h0052;
      7'h1a:   return 16'h0053;
      7'h1b:   return 16'h0054;
      7'h1c:   return 16'h0055;
      7'h1d:   return 16'h0056;
      default: return IDX_RESET;
    endcase
  endfunction

  // true when cnt words from start all fall inside base..last
  function automatic logic inRange(input logic [15:0] start, input logic [7:0] cnt,
                                   input logic [15:0] base, input logic [15:0] last);
    logic [16:0] endA;
    endA = {1'b0, start} + {9'h000, cnt} - 17'h00001;
    return (cnt != 8'h00) && (start >= base) && (endA <= {1'b0, last});
  endfunction
endpackage
`default_nettype wire

// [rur_tbl_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface rur_tbl_if;
  logic        wrEn;
  logic [6:0]  wrIdx;
  logic [15:0] wrData;
  logic [6:0]  rdIdx;
  logic [15:0] rdData;
  modport store (input wrEn, input wrIdx, input wrData, input rdIdx, output rdData);
  modport user  (output wrEn, output wrIdx, output wrData, output rdIdx, input rdData);
endinterface
`default_nettype wire

// [rur_index_store.sv]
`timescale 1ns/1ps
`default_nettype none
module rur_index_store import rur_pkg::*; (
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rst,
  // table access
  rur_tbl_if.store    tbl
);
  logic [15:0] mem [120];

  // write port; no reset on the words, the loader fills every entry after reset
  always_ff @(posedge sys_clk) begin
    if (tbl.wrEn && (tbl.wrIdx <= IDX_TOP)) begin
      mem[tbl.wrIdx] <= tbl.wrData;
    end
  end

  // read is combinational so a slot can be resolved in the fetch cycle
  assign tbl.rdData = (tbl.rdIdx <= IDX_TOP) ? mem[tbl.rdIdx] : IDX_RESET;

  a_table_readback: assert property (@(posedge sys_clk) disable iff (rst)
    tbl.wrEn && (tbl.wrIdx <= IDX_TOP) ##1 (tbl.rdIdx == $past(tbl.wrIdx)) && !tbl.wrEn
    |-> tbl.rdData == $past(tbl.wrData))
    else $error("index entry lost its written value");
endmodule // rur_index_store
`default_nettype wire

// [rur_nv_loader.sv]
`timescale 1ns/1ps
`default_nettype none
module rur_nv_loader import rur_pkg::*; (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // setpoint store read side
  output logic             nvRdReq,
  output logic [6:0]       nvRdIdx,
  input  wire logic        nvRdValid,
  input  wire logic [15:0] nvRdData,
  input  wire logic        nvBlank,
  // table fill
  output logic             ldWrEn,
  output logic [6:0]       ldIdx,
  output logic [15:0]      ldData,
  output logic             ldDone
);
  typedef enum logic [1:0] {LD_REQ, LD_WAIT, LD_DONE} rur_ld_e;
  rur_ld_e ldState;

  // walk all entries; a blank store yields the factory contents
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ldState <= LD_REQ;
      nvRdReq <= 1'b0;
      nvRdIdx <= 7'h00;
      ldWrEn  <= 1'b0;
      ldIdx   <= 7'h00;
      ldData  <= IDX_RESET;
      ldDone  <= 1'b0;
    end else begin
      nvRdReq <= 1'b0;
      ldWrEn  <= 1'b0;
      case (ldState)
        LD_REQ: begin
          nvRdReq <= 1'b1;
          ldState <= LD_WAIT;
        end
        LD_WAIT: begin
          if (nvRdValid) begin
            ldWrEn  <= 1'b1;
            ldIdx   <= nvRdIdx;
            ldData  <= nvBlank ? defaultIndex(nvRdIdx) : nvRdData;
            nvRdIdx <= nvRdIdx + 7'h01;
            ldState <= (nvRdIdx == IDX_TOP) ? LD_DONE : LD_REQ;
          end
        end
        LD_DONE: ldDone <= 1'b1;
        default: ldState <= LD_REQ;
      endcase
    end
  end

  a_blank_default: assert property (@(posedge sys_clk) disable iff (rst)
    nvRdValid && nvBlank && (ldState == LD_WAIT)
    |=> ldWrEn && ldData == defaultIndex(ldIdx))
    else $error("blank store did not load factory index");
endmodule // rur_nv_loader
`default_nettype wire

// [rur_map_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rur_map_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // test controls: source value pattern and answer speed
  input  wire logic [15:0] bias,
  input  wire logic        slow,
  // live register map
  input  wire logic        srcReq,
  input  wire logic [15:0] srcAddr,
  output logic             srcValid,
  output logic [15:0]      srcRdata,
  // setpoint store
  input  wire logic        nvRdReq,
  input  wire logic [6:0]  nvRdIdx,
  output logic             nvRdValid,
  output logic [15:0]      nvRdData,
  output logic             nvBlank,
  input  wire logic        nvWrValid,
  input  wire logic [6:0]  nvWrIdx,
  input  wire logic [15:0] nvWrData
);
  logic [15:0]  store [0:119];
  logic [119:0] written = '0;
  logic         pend    = 1'b0;
  logic [1:0]   wait_n  = 2'h0;
  logic [15:0]  fetchA  = 16'h0000;

  initial srcValid = 1'b0;
  initial nvRdValid = 1'b0;
  initial srcRdata = 16'h0000;
  initial nvRdData = 16'h0000;
  initial nvBlank = 1'b0;

  // store survives every reset of the block, like real setpoint memory
  always @(posedge sys_clk) begin
    nvRdValid <= 1'b0;
    if (nvWrValid) begin
      store[nvWrIdx]   <= nvWrData;
      written[nvWrIdx] <= 1'b1;
    end
    if (nvRdReq) begin
      nvRdValid <= 1'b1;
      nvRdData  <= store[nvRdIdx];
      nvBlank   <= !written[nvRdIdx];
    end else begin
      // idle lines toggle so a stale value is never mistaken for data
      nvRdData <= ~nvRdData;
      nvBlank  <= ~nvBlank;
    end
  end

  // live value is computed at answer time, so a bias change shows at once
  always @(posedge sys_clk) begin
    srcValid <= 1'b0;
    if (rst) begin
      pend <= 1'b0;
    end else if (srcReq) begin
      pend   <= 1'b1;
      fetchA <= srcAddr;
      wait_n <= slow ? 2'h3 : 2'h0;
    end else if (pend && wait_n == 2'h0) begin
      pend     <= 1'b0;
      srcValid <= 1'b1;
      srcRdata <= fetchA ^ bias;
    end else if (pend) begin
      wait_n <= wait_n - 2'h1;
    end else begin
      srcRdata <= ~srcRdata;
    end
  end
endmodule // rur_map_model
`default_nettype wire

// [rur_remap_window_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module rur_remap_window_tb_top import rur_pkg::*;;
  logic sys_clk = 1'b0, rst = 1'b1, slow = 1'b0;
  logic reqValid = 1'b0, reqCrcOk = 1'b1;
  logic [7:0] reqFunc = 8'h00, reqCount = 8'h00;
  logic [15:0] reqAddr = 16'h0000, reqWdata = 16'h0000, bias = 16'h5a3c;
  logic reqReady, rspValid, rspLast, excValid, srcReq, srcValid;
  logic nvRdReq, nvRdValid, nvBlank, nvWrValid;
  logic [7:0] excCode;
  logic [15:0] rspData, srcAddr, srcRdata, nvRdData, nvWrData;
  logic [6:0] nvRdIdx, nvWrIdx;
  logic [15:0] rspQ[$];
  logic [7:0] excQ[$];
  logic [7:0] gotExc;
  int err_total = 0, comparisons = 0, doneCnt = 0, cycles = 0;
  logic [15:0] defTbl [0:29] = '{16'h0014, 16'h0015, 16'h0016, 16'h001a, 16'h001b,
    16'h001c, 16'h0022, 16'h0023, 16'h0024, 16'h0030, 16'h0031, 16'h0032, 16'h0033,
    16'h0034, 16'h0035, 16'h0036, 16'h0037, 16'h0010, 16'h0013, 16'h0021, 16'h0038,
    16'h0039, 16'h003a, 16'h0050, 16'h0051, 16'h0052, 16'h0053, 16'h0054, 16'h0055,
    16'h0056};
  // function, address, count, expected exception code
  logic [39:0] badTbl [0:6] = '{{FN_WR_SINGLE, 16'h0100, 8'h01, EXC_ADDR},
    {FN_WR_MULTI, 16'h12f8, 8'h01, EXC_ADDR}, {FN_RD_INPUT, 16'h0178, 8'h01, EXC_ADDR},
    {FN_RD_HOLD, 16'h0177, 8'h02, EXC_ADDR}, {FN_RD_HOLD, 16'h1280, 8'h00, EXC_VALUE},
    {FN_RD_HOLD, 16'h1280, 8'h79, EXC_VALUE}, {8'h05, 16'h1280, 8'h01, EXC_FUNC}};

  always #50 sys_clk = ~sys_clk;

  rur_remap_window i_dut (.sys_clk(sys_clk), .rst(rst), .reqValid(reqValid),
    .reqReady(reqReady), .reqFunc(reqFunc), .reqAddr(reqAddr), .reqCount(reqCount),
    .reqWdata(reqWdata), .reqCrcOk(reqCrcOk), .rspValid(rspValid), .rspData(rspData),
    .rspLast(rspLast), .excValid(excValid), .excCode(excCode), .srcReq(srcReq),
    .srcAddr(srcAddr), .srcValid(srcValid), .srcRdata(srcRdata), .nvRdReq(nvRdReq),
    .nvRdIdx(nvRdIdx), .nvRdValid(nvRdValid), .nvRdData(nvRdData), .nvBlank(nvBlank),
    .nvWrValid(nvWrValid), .nvWrIdx(nvWrIdx), .nvWrData(nvWrData));

  rur_map_model i_map (.sys_clk(sys_clk), .rst(rst), .bias(bias), .slow(slow),
    .srcReq(srcReq), .srcAddr(srcAddr), .srcValid(srcValid), .srcRdata(srcRdata),
    .nvRdReq(nvRdReq), .nvRdIdx(nvRdIdx), .nvRdValid(nvRdValid), .nvRdData(nvRdData),
    .nvBlank(nvBlank), .nvWrValid(nvWrValid), .nvWrIdx(nvWrIdx), .nvWrData(nvWrData));

  // answer collector; pulses last exactly one cycle, so sample every edge
  always @(posedge sys_clk) begin
    if (rspValid === 1'b1) rspQ.push_back(rspData);
    if (excValid === 1'b1) excQ.push_back(excCode);
    if (rspValid === 1'b1 && rspLast === 1'b1 || excValid === 1'b1) doneCnt++;
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic doReset();
    @(posedge sys_clk);
    #1 rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 rst = 1'b0;
  endtask

  // one request held until taken, then bounded wait for its answer
  task automatic op(input logic [7:0] f, input logic [15:0] a, input logic [7:0] n,
                    input logic [15:0] d, input logic c);
    int k;
    int n0;
    @(posedge sys_clk);
    #1;
    n0 = doneCnt;
    {reqFunc, reqAddr, reqCount, reqWdata, reqCrcOk, reqValid} = {f, a, n, d, c, 1'b1};
    k = 0;
    while (reqReady !== 1'b1 && k < 2000) begin
      @(posedge sys_clk);
      #1 k++;
    end
    @(posedge sys_clk);
    #1 reqValid = 1'b0;
    k = 0;
    while (c && doneCnt == n0 && k < 600) begin
      @(posedge sys_clk);
      #1 k++;
    end
    if (!c) repeat (10) @(posedge sys_clk);
    `CHK(k < 600, 1'b1)
  endtask

  task automatic expW(input logic [15:0] e);
    logic [15:0] g;
    g = (rspQ.size() > 0) ? rspQ.pop_front() : 16'hxxxx;
    `CHK(g, e)
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] n);
    op(FN_RD_HOLD, a, n, 16'h0000, 1'b1);
    `CHK(rspQ.size(), int'(n))
  endtask

  initial begin
    doReset();
    rd(WIN_BASE, 8'h1e);
    for (int i = 0; i < 30; i++) expW(defTbl[i] ^ bias);
    rd(IDX_BASE, WIN_WORDS);
    for (int i = 0; i < 120; i++) expW(i < 30 ? defTbl[i] : 16'h0000);
    // back-to-back writes with both functions, then the last entry
    op(FN_WR_SINGLE, 16'h1280, 8'h01, 16'h0031, 1'b1);
    op(FN_WR_MULTI, 16'h1281, 8'h01, 16'h0023, 1'b1);
    op(FN_WR_MULTI, IDX_LAST, 8'h01, 16'h1234, 1'b1);
    expW(16'h0031);
    expW(16'h0023);
    expW(16'h1234);
    rd(WIN_BASE, 8'h02);
    expW(16'h0031 ^ bias);
    expW(16'h0023 ^ bias);
    rd(IDX_LAST, 8'h01);
    expW(16'h1234);
    rd(WIN_LAST, 8'h01);
    expW(16'h1234 ^ bias);
    // slow far side and a new live value
    slow = 1'b1;
    bias = 16'hc3e1;
    rd(WIN_BASE, 8'h02);
    expW(16'h0031 ^ bias);
    expW(16'h0023 ^ bias);
    for (int i = 0; i < 7; i++) begin
      op(badTbl[i][39:32], badTbl[i][31:16], badTbl[i][15:8], 16'h0000, 1'b1);
      // pop once into a variable, the compare prints its operands again on a miss
      gotExc = (excQ.size() > 0) ? excQ.pop_front() : 8'hxx;
      `CHK(gotExc, badTbl[i][7:0])
      `CHK(rspQ.size(), 0)
    end
    // corrupted frame leaves no answer and no change
    op(FN_WR_SINGLE, 16'h1282, 8'h01, 16'h0abc, 1'b0);
    `CHK(rspQ.size() + excQ.size(), 0)
    rd(16'h1282, 8'h01);
    expW(16'h0016);
    // written entries come back from the store, blank ones from defaults
    doReset();
    rd(IDX_BASE, 8'h03);
    expW(16'h0031);
    expW(16'h0023);
    expW(16'h0016);
    rd(IDX_LAST, 8'h01);
    expW(16'h1234);
    results();
  end
endmodule // rur_remap_window_tb_top
`default_nettype wire
